// ==== fpio_pkg.sv ====
/*
  Constants for the four-pin I/O port: register addresses, field
  positions, reset values, operation codes and instruction-cycle timing.
  Assumes one system clock per instruction-cycle phase.
*/
package fpio_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_PORT = 8'h06;

  // ==========================================================
  // Widths and field positions
  localparam int PORT_WIDTH = 4;
  localparam int OUT_PINS = 3;
  localparam int INPUT_ONLY_BIT = 3;
  localparam int STATUS_PIN_WAKE_BIT = 7;
  localparam int STATUS_CMP_WAKE_BIT = 6;
  localparam int STATUS_CORE_WIDTH = 5;

  // ==========================================================
  // Reset values
  localparam logic [3:0] DIR_RESET = 4'hf;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [2:0] LATCH_RESET = 3'h0;

  // ==========================================================
  // Operation codes on the core request port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_BIT_SET = 3'h2;
  localparam logic [2:0] OP_BIT_CLEAR = 3'h3;
  localparam logic [2:0] OP_DIR_LOAD = 3'h4;
  localparam logic [2:0] OP_OPTION_LOAD = 3'h5;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int Q_PHASES = 4;
  localparam int CYCLE_CLOCKS = Q_PHASES;
  localparam logic [1:0] EXEC_LAST = 2'(CYCLE_CLOCKS - 2);

  // ==========================================================
  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } fpio_state_t;

endpackage : fpio_pkg

// ==== fpio_link_if.sv ====
/*
  Internal carrier between the port core and its two helper modules:
  synchronised pin levels and the captured wake-up cause flags.
  Assumes all three modules run on the same clock.
*/
`timescale 1ns/1ps
interface fpio_link_if;
  logic [3:0] pins_sync;
  logic pin_wake_flag;
  logic cmp_wake_flag;

  modport sync_src (output pins_sync);
  modport flag_src (output pin_wake_flag, output cmp_wake_flag);
  modport core (input pins_sync, input pin_wake_flag, input cmp_wake_flag);
endinterface : fpio_link_if

// ==== fpio_sync.sv ====
/*
  Two-flop synchroniser for the four raw pin levels.
  Assumes pins are asynchronous to the system clock.
*/
`timescale 1ns/1ps
module fpio_sync
  import fpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pins_raw_i,
  fpio_link_if.sync_src link
);

  // ==========================================================
  // Synchroniser stages
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;

  always_comb begin
    meta_next = pins_raw_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign link.pins_sync = sync_reg;

endmodule : fpio_sync

// ==== fpio_status.sv ====
/*
  Wake-up cause flags. Every reset clears them; on the first clock after
  release the cause levels are caught once and then held.
  Assumes the cause inputs are stable on the system clock at release.
*/
`timescale 1ns/1ps
module fpio_status
  import fpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wake_pin_cause_i,
  input wire logic wake_cmp_cause_i,
  fpio_link_if.flag_src link
);

  // ==========================================================
  // Capture after release
  logic armed_reg;
  logic armed_next;
  logic pin_flag_reg;
  logic pin_flag_next;
  logic cmp_flag_reg;
  logic cmp_flag_next;

  always_comb begin
    armed_next = 1'b1;
    pin_flag_next = pin_flag_reg;
    cmp_flag_next = cmp_flag_reg;
    if (!armed_reg) begin
      pin_flag_next = wake_pin_cause_i;
      cmp_flag_next = wake_cmp_cause_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_reg <= 1'b0;
      pin_flag_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      pin_flag_reg <= pin_flag_next;
      cmp_flag_reg <= cmp_flag_next;
    end
  end

  assign link.pin_wake_flag = pin_flag_reg;
  assign link.cmp_wake_flag = cmp_flag_reg;

endmodule : fpio_status

// ==== fpio_top.sv ====
/*
  Four-pin I/O port core: direction bits, output latches, option bits,
  port and status reads, read-modify-write bit operations, all paced by
  a four-phase instruction cycle.
  Assumes the processor core issues one request at a time and waits for
  REQ_READY_O; pins are asynchronous and pass a two-flop synchroniser.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Pins zero to two can drive or sense, while the input-only pin never drives.
// - Port reads return the sampled pin levels, never the output latch values.
// - Output latches hold their value until the port is written again.
// - A direction bit of 0 drives the pin and a 1 leaves it undriven as an input.
// - Each bidirectional pin has its own direction bit, so pins mix freely.
// - Unused bit positions of the port and status registers read as zero.
// - The pin-change wake flag is 1 after a pin-change wake reset and 0 otherwise.
// - The comparator wake flag is 1 after a comparator wake reset and 0 otherwise.
// - Bit set and bit clear read the whole port from the pins and write all latches back.
// - In that rewrite, a pin set as input gets its sampled level put into its latch.
// - A port write reaches the latches and pins at the end of the instruction cycle.
// - A port read samples the pins at the start of the cycle, so it may see old levels.
// - A port read shows the pin level even when an enabled driver is overpowered.
// - The direction register is write-only and all ones after every reset.
// - The direction register loads from the working value on the direction load.
module fpio_top
  import fpio_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [3:0] PIN_IN_I,
  output logic [2:0] PIN_OUT_O,
  output logic [2:0] PIN_OE_O,
  input wire logic REQ_VALID_I,
  input wire logic [2:0] REQ_OP_I,
  input wire logic [7:0] REQ_ADDR_I,
  input wire logic [2:0] REQ_BIT_I,
  input wire logic [7:0] REQ_DATA_I,
  input wire logic [4:0] CORE_STATUS_I,
  input wire logic WAKE_PIN_CAUSE_I,
  input wire logic WAKE_CMP_CAUSE_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic [7:0] RD_DATA_O,
  output logic [7:0] OPTION_O
);

  // ==========================================================
  // Helper functions

  // Sets or clears one bit of a byte
  function automatic logic [7:0] fpio_bit_modify(
    input logic [7:0] value,
    input logic [2:0] idx,
    input logic set_bit
  );
    logic [7:0] result;
    result = value;
    result[idx] = set_bit;
    return result;
  endfunction : fpio_bit_modify

  // Widens the four pin levels to a register byte
  function automatic logic [7:0] fpio_port_byte(input logic [3:0] pins);
    return {4'h0, pins};
  endfunction : fpio_port_byte

  // ==========================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Helper modules
  fpio_link_if link ();

  fpio_sync u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_n_reg),
    .pins_raw_i(PIN_IN_I),
    .link(link.sync_src)
  );

  fpio_status u_status (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_n_reg),
    .wake_pin_cause_i(WAKE_PIN_CAUSE_I),
    .wake_cmp_cause_i(WAKE_CMP_CAUSE_I),
    .link(link.flag_src)
  );

  // ==========================================================
  // Instruction-cycle sequencer
  fpio_state_t state_reg;
  fpio_state_t state_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [2:0] op_reg;
  logic [2:0] op_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic [3:0] sample_reg;
  logic [3:0] sample_next;
  logic [4:0] core_reg;
  logic [4:0] core_next;
  logic finish;
  logic accept;

  assign REQ_READY_O = (state_reg == ST_IDLE);
  assign accept = REQ_VALID_I && (state_reg == ST_IDLE);

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    bit_next = bit_reg;
    wdata_next = wdata_reg;
    sample_next = sample_reg;
    core_next = core_reg;
    finish = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          op_next = REQ_OP_I;
          addr_next = REQ_ADDR_I;
          bit_next = REQ_BIT_I;
          wdata_next = REQ_DATA_I;
          sample_next = link.pins_sync;
          core_next = CORE_STATUS_I;
          phase_next = 2'h0;
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (phase_reg == EXEC_LAST) begin
          finish = 1'b1;
          state_next = ST_IDLE;
        end else begin
          phase_next = phase_reg + 2'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
      op_reg <= OP_READ;
      addr_reg <= 8'h00;
      bit_reg <= 3'h0;
      wdata_reg <= 8'h00;
      sample_reg <= 4'h0;
      core_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      bit_reg <= bit_next;
      wdata_reg <= wdata_next;
      sample_reg <= sample_next;
      core_reg <= core_next;
    end
  end

  // ==========================================================
  // Port, direction and option registers
  logic [2:0] latch_reg;
  logic [2:0] latch_next;
  logic [3:0] dir_reg;
  logic [3:0] dir_next;
  logic [7:0] option_reg;
  logic [7:0] option_next;
  logic [7:0] rmw_value;
  logic is_port;

  assign is_port = (addr_reg == ADDR_PORT);

  always_comb begin
    rmw_value = fpio_bit_modify(fpio_port_byte(sample_reg), bit_reg,
                                (op_reg == OP_BIT_SET));
  end

  always_comb begin
    latch_next = latch_reg;
    dir_next = dir_reg;
    option_next = option_reg;
    if (finish) begin
      case (op_reg)
        OP_WRITE: begin
          if (is_port) begin
            latch_next = wdata_reg[OUT_PINS-1:0];
          end
        end
        OP_BIT_SET, OP_BIT_CLEAR: begin
          if (is_port) begin
            latch_next = rmw_value[OUT_PINS-1:0];
          end
        end
        OP_DIR_LOAD: begin
          dir_next = wdata_reg[PORT_WIDTH-1:0];
        end
        OP_OPTION_LOAD: begin
          option_next = wdata_reg;
        end
        default: begin
          latch_next = latch_reg;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      latch_reg <= LATCH_RESET;
      dir_reg <= DIR_RESET;
      option_reg <= OPTION_RESET;
    end else begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      option_reg <= option_next;
    end
  end

  // ==========================================================
  // Read data and completion
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic done_reg;
  logic done_next;
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[STATUS_PIN_WAKE_BIT] = link.pin_wake_flag;
    status_byte[STATUS_CMP_WAKE_BIT] = link.cmp_wake_flag;
    status_byte[STATUS_CORE_WIDTH-1:0] = core_reg;
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    done_next = finish;
    if (finish) begin
      rd_data_next = 8'h00;
      if (op_reg == OP_READ) begin
        if (is_port) begin
          rd_data_next = fpio_port_byte(sample_reg);
        end else if (addr_reg == ADDR_STATUS) begin
          rd_data_next = status_byte;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_data_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // Pin drivers
  always_comb begin
    PIN_OE_O = ~dir_reg[OUT_PINS-1:0];
    PIN_OUT_O = latch_reg;
  end

  // input-only pin has no driver
  // Bit INPUT_ONLY_BIT of dir_reg is stored but unused; that bit of PIN_IN_I is sensed only.

  assign DONE_O = done_reg;
  assign RD_DATA_O = rd_data_reg;
  assign OPTION_O = option_reg;

endmodule : fpio_top

// ==== fpio_props.sv ====
/* Checker for the port core, bound into fpio_top.
   Assumes one clock and the active-low reset NRST_I. */
`timescale 1ns/1ps
module fpio_props
  import fpio_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [3:0] PIN_IN_I,
  input wire logic [2:0] PIN_OUT_O,
  input wire logic [2:0] PIN_OE_O,
  input wire logic REQ_VALID_I,
  input wire logic [2:0] REQ_OP_I,
  input wire logic [7:0] REQ_ADDR_I,
  input wire logic [2:0] REQ_BIT_I,
  input wire logic [7:0] REQ_DATA_I,
  input wire logic [4:0] CORE_STATUS_I,
  input wire logic REQ_READY_O,
  input wire logic DONE_O,
  input wire logic [7:0] RD_DATA_O
);
  // ======
  // Age since reset and request decode
  logic [3:0] age_reg;
  logic [3:0] age_next;
  logic tk;
  logic tkp;
  assign tk = REQ_VALID_I && REQ_READY_O && age_reg > 4'h1;
  assign tkp = tk && age_reg == 4'hf && REQ_ADDR_I == ADDR_PORT;
  always_comb begin
    age_next = age_reg + {3'h0, age_reg != 4'hf};
  end
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      age_reg <= 4'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  default clocking @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ======
  // Assertions
  // answer timing
  chk_done_timing: assert property (tk |=> !REQ_READY_O [*3] ##1
    (DONE_O && REQ_READY_O)) else $error("done timing wrong");
  chk_dir_enable: assert property (tk && REQ_OP_I == OP_DIR_LOAD
    |-> ##4 (PIN_OE_O ^ $past(REQ_DATA_I[2:0], 4)) == 3'h7)
    else $error("enable not inverse of direction");
  chk_write_latch: assert property (tk && REQ_OP_I == OP_WRITE &&
    REQ_ADDR_I == ADDR_PORT |-> ##4 PIN_OUT_O == $past(REQ_DATA_I[2:0], 4))
    else $error("latch not written");
  chk_latch_hold: assert property (!$stable(PIN_OUT_O) |-> DONE_O)
    else $error("latch changed alone");
  chk_dir_hold: assert property ($changed(PIN_OE_O) |-> DONE_O)
    else $error("enable changed alone");
  chk_read_pins: assert property ($stable(PIN_IN_I) [*4] ##0
    (tkp && REQ_OP_I == OP_READ) |-> ##4
    RD_DATA_O == {4'h0, $past(PIN_IN_I, 4)})
    else $error("port read not pin levels");
  chk_rmw_set: assert property ($stable(PIN_IN_I) [*4] ##0
    (tkp && REQ_OP_I == OP_BIT_SET) |-> ##4
    PIN_OUT_O == ($past(PIN_IN_I[2:0], 4) | (3'h1 << $past(REQ_BIT_I, 4))))
    else $error("bit set rewrite wrong");
  chk_status_bits: assert property (tk && REQ_OP_I == OP_READ &&
    REQ_ADDR_I == ADDR_STATUS |-> ##4
    RD_DATA_O[5:0] == {1'h0, $past(CORE_STATUS_I, 4)})
    else $error("status read wrong");
endmodule : fpio_props
bind fpio_top fpio_props u_props (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
  .PIN_IN_I(PIN_IN_I), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_O(PIN_OE_O),
  .REQ_VALID_I(REQ_VALID_I), .REQ_OP_I(REQ_OP_I), .REQ_ADDR_I(REQ_ADDR_I),
  .REQ_BIT_I(REQ_BIT_I), .REQ_DATA_I(REQ_DATA_I),
  .CORE_STATUS_I(CORE_STATUS_I), .REQ_READY_O(REQ_READY_O),
  .DONE_O(DONE_O), .RD_DATA_O(RD_DATA_O));

// ==== fpio_ext_model.sv ====
/* Pin-side circuitry: holds chosen pins, else follows drivers; undriven pins toggle.
   Assumes the bench picks which pins it holds. */
`timescale 1ns/1ps
module fpio_ext_model (
  input wire logic clk_i,
  input wire logic [2:0] out_i,
  input wire logic [2:0] oe_i,
  input wire logic [2:0] hold_i,
  input wire logic [3:0] lvl_i,
  output logic [3:0] pins_o
);
  logic [2:0] flt_reg = 3'h0;
  // ======
  // Undriven pins wander each cycle
  always @(posedge clk_i) begin
    flt_reg <= ~pins_o[2:0];
  end
  assign pins_o = {lvl_i[3], (hold_i & lvl_i[2:0]) |
    (~hold_i & ((oe_i & out_i) | (~oe_i & flt_reg)))};
endmodule : fpio_ext_model

// ==== tb.sv ====
/* Bench for the port core with a pin-side model.
   Assumes fpio_top, fpio_ext_model and fpio_props are compiled. */
`timescale 1ns/1ps
`define CHK(g, x) begin \
  num_checks++; \
  if ((g) !== (x)) begin \
    mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, x); \
  end \
end
module tb;
  import fpio_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic vld = 1'h0;
  logic [2:0] rop = 3'h0;
  logic [7:0] radr = 8'h0;
  logic [2:0] rbit = 3'h0;
  logic [7:0] rdat = 8'h0;
  logic [4:0] cst = 5'h0;
  logic [1:0] wk = 2'h0;
  logic [2:0] xe = 3'h7;
  logic [3:0] xv = 4'h0;
  logic [3:0] pin;
  logic [2:0] pout;
  logic [2:0] poe;
  logic rdy;
  logic done;
  logic [7:0] rd;
  logic [7:0] opt;
  logic [2:0] lat;
  logic [2:0] oem;
  logic [7:0] e;
  logic [13:0] ex;
  logic [13:0] exp_q[$];
  int mismatches = 0;
  int num_checks = 0;
  fpio_top dut (.SYS_CLK_I(clk), .NRST_I(nrst), .PIN_IN_I(pin),
    .PIN_OUT_O(pout), .PIN_OE_O(poe), .REQ_VALID_I(vld), .REQ_OP_I(rop),
    .REQ_ADDR_I(radr), .REQ_BIT_I(rbit), .REQ_DATA_I(rdat),
    .CORE_STATUS_I(cst), .WAKE_PIN_CAUSE_I(wk[1]),
    .WAKE_CMP_CAUSE_I(wk[0]), .REQ_READY_O(rdy), .DONE_O(done),
    .RD_DATA_O(rd), .OPTION_O(opt));
  fpio_ext_model u_ext (.clk_i(clk), .out_i(pout), .oe_i(poe),
    .hold_i(xe), .lvl_i(xv), .pins_o(pin));
  // ======
  // Helpers
  function automatic logic [3:0] pv();
    pv = {xv[3], (xe & xv[2:0]) | (~xe & lat)};
  endfunction : pv
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic idle(input int n);
    vld <= 1'h0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic op(input logic [2:0] o, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] d, input logic [7:0] x);
    int n;
    n = 0;
    vld <= 1'h1;
    rop <= o;
    radr <= a;
    rbit <= b;
    rdat <= d;
    exp_q.push_back({x, lat, ~oem});
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'h1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      summarize();
    end
  endtask : op
  task automatic rst(input logic [1:0] c);
    idle(6);
    nrst <= 1'h0;
    wk <= c;
    xe <= 3'h7;
    xv <= 4'($urandom());
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (16) @(posedge clk);
    lat = 3'h0;
    oem = 3'h7;
    `CHK({pout, poe, opt, rdy}, {6'h0, OPTION_RESET, 1'h1})
  endtask : rst
  // ======
  // Clock and result monitor
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (done === 1'h1) begin
      ex = 'x;
      if (exp_q.size() > 0) begin
        ex = exp_q.pop_front();
      end
      `CHK({rd, pout, poe}, ex)
    end
  end
  // ======
  // Main sequence
  initial begin
    void'($urandom(34));
    @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      rst(k[1:0]);
      e = 8'($urandom());
      cst <= e[4:0];
      op(OP_WRITE, ADDR_STATUS, 3'h0, e, 8'h0);
      op(OP_BIT_CLEAR, ADDR_STATUS, 3'h7, e, 8'h0);
      op(OP_READ, 8'h05, 3'h0, e, 8'h0);
      op(k[0] ? 3'h7 : 3'h6, ADDR_PORT, 3'h0, e, 8'h0);
      op(OP_OPTION_LOAD, 8'h0, 3'h0, e, 8'h0);
      op(OP_READ, ADDR_STATUS, 3'h0, 8'h0, {k[1:0], 1'h0, e[4:0]});
      `CHK(opt, e)
    end
    $display("status test done");
    for (int k = 0; k < 8; k++) begin
      xe <= k[2:0];
      xv <= 4'($urandom());
      oem = k[2:0];
      op(OP_DIR_LOAD, 8'h0, 3'h0, {5'($urandom()), k[2:0]}, 8'h0);
      idle(6);
      e = {4'h0, pv()};
      lat = 3'($urandom());
      op(OP_WRITE, ADDR_PORT, 3'h0, {5'($urandom()), lat}, 8'h0);
      // read right after write sees old levels
      op(OP_READ, ADDR_PORT, 3'h0, 8'h0, e);
      idle(6);
      op(OP_READ, ADDR_PORT, 3'h0, 8'h0, {4'h0, pv()});
    end
    $display("direction test done");
    xe <= 3'h3;
    xv <= 4'($urandom()) | 4'h2;
    oem = 3'h1;
    op(OP_DIR_LOAD, 8'h0, 3'h0, 8'h01, 8'h0);
    idle(6);
    for (int b = 0; b < 8; b++) begin
      e = {4'h0, pv()};
      lat = e[2:0];
      if (b < 3) begin
        lat[b] = ~b[0];
      end
      op(b[0] ? OP_BIT_CLEAR : OP_BIT_SET, ADDR_PORT, b[2:0], 8'h0, 8'h0);
      idle(6);
    end
    lat = 3'h0;
    op(OP_WRITE, ADDR_PORT, 3'h0, 8'h0, 8'h0);
    idle(6);
    // held pin reads its own level
    op(OP_READ, ADDR_PORT, 3'h0, 8'h0, {4'h0, pv()});
    idle(8);
    $display("rewrite test done");
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule : tb
